// ===== rtl/hffc_pkg.sv
// Constants for the frame FIFO host control block
package hffc_pkg;
  localparam int unsigned CLK_HZ        = 50000000;
  localparam int unsigned FIFO_DEPTH    = 64;
  localparam logic [6:0]  FIFO_FULL     = 7'h40;
  localparam logic [6:0]  BLOCK_32      = 7'h20;
  localparam logic [6:0]  BLOCK_16      = 7'h10;
  localparam int unsigned RX_SCAN       = 32;
  // Register byte offsets
  localparam logic [7:0]  ADDR_DATA     = 8'h00;
  localparam logic [7:0]  ADDR_CMD      = 8'h04;
  localparam logic [7:0]  ADDR_CFG      = 8'h08;
  localparam logic [7:0]  ADDR_STATUS   = 8'h0C;
  localparam logic [7:0]  ADDR_IRQ      = 8'h10;
  localparam logic [7:0]  ADDR_MASK     = 8'h14;
  localparam logic [7:0]  ADDR_CNT_LO   = 8'h18;
  localparam logic [7:0]  ADDR_CNT_HI   = 8'h1C;
  // command_reg bits
  localparam int unsigned CMD_RMC       = 7;
  localparam int unsigned CMD_XTF       = 3;
  localparam int unsigned CMD_XME       = 1;
  localparam int unsigned CMD_TX_RESET_CMD      = 0;
  // extended_mode_cfg bits
  localparam int unsigned CFG_TX_BS     = 5;
  localparam logic [7:0]  CFG_RESET     = 8'h00;
  // general_status bits
  localparam int unsigned ST_TX_OVERFLOW_FLAG       = 7;
  localparam int unsigned ST_XFW        = 6;
  // framer_irq_status bits
  localparam int unsigned IRQ_RPF       = 7;
  localparam int unsigned IRQ_RME       = 6;
  localparam int unsigned IRQ_XPR       = 4;
  localparam int unsigned IRQ_XMR       = 3;
  localparam int unsigned IRQ_XDU       = 2;
  localparam logic [7:0]  MASK_RESET    = 8'h00;
  // rx_status_byte bits
  localparam int unsigned RS_VFR        = 7;
  localparam int unsigned RS_RDO        = 6;
  localparam int unsigned RS_CRC        = 5;
  localparam int unsigned RS_RAB        = 4;
  localparam int unsigned RS_TA         = 3;
  // rx_count_high bits
  localparam int unsigned CNT_OV        = 4;
endpackage : hffc_pkg

// ===== rtl/hffc_top.sv
// Frame FIFO host control: receive and transmit 64-byte queues behind AHB-Lite
`timescale 1ns/100ps
`default_nettype none

module hffc_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        mode_transparent0,
  input  wire logic        rx_byte_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_frame_end,
  input  wire logic        rx_crc_ok,
  input  wire logic        rx_frame_valid,
  input  wire logic        rx_abort_seen,
  input  wire logic        rx_tei_hit,
  output logic             tx_valid,
  output logic      [7:0]  tx_data,
  output logic             tx_first,
  output logic             tx_last,
  output logic             tx_abort,
  input  wire logic        tx_ready,
  input  wire logic        tx_flag_done,
  input  wire logic        tx_collision,
  output logic             irq
);

  function automatic logic [7:0] hffc_find_end(input logic [63:0] marks,
                                               input logic [5:0]  base,
                                               input logic [6:0]  avail);
    logic       found;
    logic [6:0] len;
    logic [5:0] idx;
    found = 1'b0;
    len   = 7'h00;
    for (int i = 0; i < hffc_pkg::RX_SCAN; i++) begin
      idx = base + i[5:0];
      if (!found && (i[6:0] < avail) && marks[idx]) begin
        found = 1'b1;
        len   = i[6:0] + 7'h01;
      end
    end
    return {found, len};
  endfunction : hffc_find_end

  // Bus slave
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic [7:0]  hrdata_reg;
  logic        hreadyout_reg;
  logic [7:0]  cfg_reg;
  logic [7:0]  mask_reg;
  logic [7:0]  irq_st_reg;
  logic        irq_reg;

  wire         acc_a    = hsel && htrans[1] && hready;
  wire  [7:0]  addr_a   = {haddr[7:2], 2'b00};
  wire         rd_a     = acc_a && !hwrite;
  wire         rx_pop   = rd_a && (addr_a == hffc_pkg::ADDR_DATA);
  wire         st_read  = rd_a && (addr_a == hffc_pkg::ADDR_IRQ);
  wire         cmd_wr   = wr_pend_reg && (wr_addr_reg == hffc_pkg::ADDR_CMD);
  wire         tx_push  = wr_pend_reg && (wr_addr_reg == hffc_pkg::ADDR_DATA);
  wire         rx_message_complete_cmd      = cmd_wr && hwdata[hffc_pkg::CMD_RMC];
  wire         tx_frame_cmd      = cmd_wr && hwdata[hffc_pkg::CMD_XTF];
  wire         tx_frame_end_cmd      = cmd_wr && hwdata[hffc_pkg::CMD_XME];
  wire         tx_reset_cmd     = cmd_wr && hwdata[hffc_pkg::CMD_TX_RESET_CMD];

  // Receive queue
  logic [7:0]  rx_mem [0:hffc_pkg::FIFO_DEPTH-1];
  logic [63:0] rx_mark_reg;
  logic [6:0]  rx_wr_reg;
  logic [6:0]  rx_ind_reg;
  logic [5:0]  rx_rd_reg;
  logic [6:0]  rx_len_reg;
  logic        rx_busy_reg;
  logic        rx_end_reg;
  logic        rx_ovf_reg;
  logic [11:0] rx_cnt_reg;
  logic        rx_cnt_ov_reg;

  wire  [6:0]  rx_fill  = rx_wr_reg - rx_ind_reg;
  wire         rx_space = (rx_fill != hffc_pkg::FIFO_FULL);
  wire  [7:0]  rx_scan  = hffc_find_end(rx_mark_reg, rx_ind_reg[5:0], rx_fill);
  wire         ev_rme   = !rx_busy_reg && rx_scan[7];
  wire         ev_rpf   = !rx_busy_reg && !rx_scan[7] && (rx_fill >= hffc_pkg::BLOCK_32);
  wire  [6:0]  rx_new_len = ev_rme ? rx_scan[6:0] : hffc_pkg::BLOCK_32;
  wire  [12:0] rx_cnt_sum = {1'b0, rx_cnt_reg} + {6'h00, rx_new_len};
  wire  [7:0]  rx_stat_byte = {rx_frame_valid, rx_ovf_reg || (rx_byte_valid && !rx_space),
                               rx_crc_ok, rx_abort_seen,
                               rx_tei_hit && !mode_transparent0, 3'b000};

  // Space is only freed by the complete command, so unread bytes are never overwritten
  always_ff @(posedge hclk) begin
    if (rx_byte_valid && rx_space) begin
      rx_mem[rx_wr_reg[5:0]] <= rx_byte;
    end else if (rx_frame_end && rx_space) begin
      rx_mem[rx_wr_reg[5:0]] <= rx_stat_byte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_wr_reg   <= 7'h00;
      rx_mark_reg <= 64'h0000000000000000;
      rx_ovf_reg  <= 1'b0;
    end else if (rx_byte_valid) begin
      if (rx_space) begin
        rx_mark_reg[rx_wr_reg[5:0]] <= 1'b0;
        rx_wr_reg                   <= rx_wr_reg + 7'h01;
      end else begin
        rx_ovf_reg <= 1'b1;
      end
    end else if (rx_frame_end) begin
      rx_ovf_reg <= 1'b0;
      if (rx_space) begin
        rx_mark_reg[rx_wr_reg[5:0]] <= 1'b1;
        rx_wr_reg                   <= rx_wr_reg + 7'h01;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_ind_reg    <= 7'h00;
      rx_rd_reg     <= 6'h00;
      rx_len_reg    <= 7'h00;
      rx_busy_reg   <= 1'b0;
      rx_end_reg    <= 1'b0;
      rx_cnt_reg    <= 12'h000;
      rx_cnt_ov_reg <= 1'b0;
    end else if (rx_message_complete_cmd && rx_busy_reg) begin
      rx_ind_reg  <= rx_ind_reg + rx_len_reg;
      rx_rd_reg   <= rx_ind_reg[5:0] + rx_len_reg[5:0];
      rx_busy_reg <= 1'b0;
      if (rx_end_reg) begin
        rx_cnt_reg    <= 12'h000;
        rx_cnt_ov_reg <= 1'b0;
      end
    end else begin
      if (rx_pop) begin
        rx_rd_reg <= rx_rd_reg + 6'h01;
      end
      if (ev_rme || ev_rpf) begin
        rx_busy_reg   <= 1'b1;
        rx_len_reg    <= rx_new_len;
        rx_end_reg    <= ev_rme;
        rx_cnt_reg    <= rx_cnt_sum[11:0];
        rx_cnt_ov_reg <= rx_cnt_ov_reg || rx_cnt_sum[12];
      end
    end
  end

  // Transmit queue
  logic [7:0]  tx_mem [0:hffc_pkg::FIFO_DEPTH-1];
  logic [6:0]  tx_wr_reg;
  logic [6:0]  tx_commit_reg;
  logic [6:0]  tx_rd_reg;
  logic [6:0]  tx_fstart_reg;
  logic [6:0]  tx_end_reg;
  logic        tx_end_valid_reg;
  logic [6:0]  tx_blk_reg;
  logic [6:0]  tx_sent_reg;
  logic        tx_bs16_reg;
  logic        tx_tx_overflow_flag_reg;
  logic        tx_lock_reg;
  logic        tx_err_lock_reg;
  logic        tx_xpr_wait_reg;
  logic        tx_in_frame_reg;
  logic        tx_valid_reg;
  logic [7:0]  tx_data_reg;
  logic        tx_first_reg;
  logic        tx_last_reg;
  logic        tx_abort_reg;

  wire  [6:0]  tx_size  = tx_bs16_reg ? hffc_pkg::BLOCK_16 : hffc_pkg::BLOCK_32;
  wire  [6:0]  tx_used  = tx_wr_reg - tx_rd_reg;
  wire  [6:0]  tx_free  = hffc_pkg::FIFO_FULL - tx_used;
  wire         tx_xfw   = !tx_lock_reg && !tx_err_lock_reg && (tx_free >= tx_size);
  wire         tx_take  = !tx_valid_reg || tx_ready;
  wire         tx_have  = (tx_rd_reg != tx_commit_reg);
  wire  [6:0]  tx_rd_inc = tx_rd_reg + 7'h01;
  wire         tx_at_end = tx_end_valid_reg && (tx_rd_inc == tx_end_reg);
  wire         tx_under = tx_in_frame_reg && tx_take && !tx_have;
  wire         tx_late  = tx_in_frame_reg && tx_collision && (tx_sent_reg > tx_size);
  wire         new_bs16 = cfg_reg[hffc_pkg::CFG_TX_BS];
  wire         ev_xdu   = !tx_reset_cmd && tx_under;
  wire         ev_xmr   = !tx_reset_cmd && !tx_under && tx_late;
  wire         ev_xpr   = tx_reset_cmd || (tx_xpr_wait_reg && tx_xfw)
                          || (tx_lock_reg && tx_flag_done);

  always_ff @(posedge hclk) begin
    if (tx_push && !tx_err_lock_reg) begin
      tx_mem[tx_wr_reg[5:0]] <= hwdata[7:0];
    end
  end

  // Only one frame end is tracked; frame commands written while a frame end is pending (until its last byte is loaded into tx_data) are ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_wr_reg <= 7'h00; tx_commit_reg <= 7'h00; tx_rd_reg <= 7'h00;
      tx_fstart_reg <= 7'h00; tx_end_reg <= 7'h00; tx_end_valid_reg <= 1'b0;
      tx_blk_reg <= 7'h00; tx_sent_reg <= 7'h00; tx_bs16_reg <= 1'b0;
      tx_tx_overflow_flag_reg <= 1'b0; tx_lock_reg <= 1'b0; tx_err_lock_reg <= 1'b0;
      tx_xpr_wait_reg <= 1'b0; tx_in_frame_reg <= 1'b0;
      tx_valid_reg <= 1'b0; tx_data_reg <= 8'h00; tx_first_reg <= 1'b0;
      tx_last_reg <= 1'b0; tx_abort_reg <= 1'b0;
    end else if (tx_reset_cmd || tx_under || tx_late) begin
      tx_wr_reg <= 7'h00; tx_commit_reg <= 7'h00; tx_rd_reg <= 7'h00;
      tx_end_valid_reg <= 1'b0; tx_blk_reg <= 7'h00; tx_sent_reg <= 7'h00;
      tx_lock_reg <= 1'b0; tx_xpr_wait_reg <= 1'b0; tx_in_frame_reg <= 1'b0;
      tx_valid_reg <= 1'b0; tx_first_reg <= 1'b0; tx_last_reg <= 1'b0;
      tx_abort_reg <= !tx_reset_cmd;
      tx_err_lock_reg <= !tx_reset_cmd;
      if (tx_reset_cmd) begin
        tx_bs16_reg <= new_bs16;
        tx_tx_overflow_flag_reg <= 1'b0;
      end
    end else begin
      tx_abort_reg <= 1'b0;
      if (st_read && (irq_st_reg[hffc_pkg::IRQ_XDU] || irq_st_reg[hffc_pkg::IRQ_XMR])) begin
        tx_err_lock_reg <= 1'b0;
      end
      if (tx_push && !tx_err_lock_reg) begin
        tx_wr_reg  <= tx_wr_reg + 7'h01;
        tx_blk_reg <= tx_blk_reg + 7'h01;
        if (tx_blk_reg >= tx_size) begin
          tx_tx_overflow_flag_reg <= 1'b1;
        end
      end
      if ((tx_frame_cmd || tx_frame_end_cmd) && !tx_end_valid_reg) begin
        tx_commit_reg <= tx_wr_reg;
        tx_blk_reg    <= 7'h00;
        tx_bs16_reg   <= new_bs16;
        if (tx_frame_end_cmd) begin
          tx_end_reg       <= tx_wr_reg;
          tx_end_valid_reg <= 1'b1;
        end
        if (tx_frame_cmd && tx_frame_end_cmd) begin
          tx_lock_reg <= 1'b1;
        end else begin
          tx_xpr_wait_reg <= 1'b1;
        end
      end else if (tx_xpr_wait_reg && tx_xfw) begin
        tx_xpr_wait_reg <= 1'b0;
      end
      if (tx_lock_reg && tx_flag_done) begin
        tx_lock_reg <= 1'b0;
      end
      if (tx_collision && tx_in_frame_reg) begin
        tx_rd_reg       <= tx_fstart_reg;
        tx_sent_reg     <= 7'h00;
        tx_in_frame_reg <= 1'b0;
        tx_valid_reg    <= 1'b0;
        tx_first_reg    <= 1'b0;
        tx_last_reg     <= 1'b0;
      end else if (tx_take && tx_have) begin
        tx_data_reg     <= tx_mem[tx_rd_reg[5:0]];
        tx_valid_reg    <= 1'b1;
        tx_first_reg    <= !tx_in_frame_reg;
        tx_last_reg     <= tx_at_end;
        tx_rd_reg       <= tx_rd_inc;
        tx_in_frame_reg <= !tx_at_end;
        if (!tx_in_frame_reg) begin
          tx_fstart_reg <= tx_rd_reg;
          tx_sent_reg   <= 7'h01;
        end else if (tx_sent_reg != 7'h7F) begin
          tx_sent_reg <= tx_sent_reg + 7'h01;
        end
        if (tx_at_end) begin
          tx_end_valid_reg <= 1'b0;
        end
      end else if (tx_take) begin
        tx_valid_reg <= 1'b0;
        tx_first_reg <= 1'b0;
        tx_last_reg  <= 1'b0;
      end
    end
  end

  // Register read mux
  wire  [7:0]  status_val = {tx_tx_overflow_flag_reg, tx_xfw, 6'h00};
  wire  [7:0]  cnt_hi_val = {3'b000, rx_cnt_ov_reg, rx_cnt_reg[11:8]};
  wire  [7:0]  rd_val =
      (addr_a == hffc_pkg::ADDR_DATA)   ? rx_mem[rx_rd_reg] :
      (addr_a == hffc_pkg::ADDR_CFG)    ? cfg_reg :
      (addr_a == hffc_pkg::ADDR_STATUS) ? status_val :
      (addr_a == hffc_pkg::ADDR_IRQ)    ? irq_st_reg :
      (addr_a == hffc_pkg::ADDR_MASK)   ? mask_reg :
      (addr_a == hffc_pkg::ADDR_CNT_LO) ? rx_cnt_reg[7:0] :
      (addr_a == hffc_pkg::ADDR_CNT_HI) ? cnt_hi_val : 8'h00;
  wire  [7:0]  ev_set = {ev_rpf, ev_rme, 1'b0, ev_xpr, ev_xmr, ev_xdu, 2'b00};
  wire  [7:0]  ev_clr = st_read ? irq_st_reg : 8'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg   <= 1'b0;
      wr_addr_reg   <= 8'h00;
      hrdata_reg    <= 8'h00;
      hreadyout_reg <= 1'b0;
    end else begin
      hreadyout_reg <= 1'b1;
      wr_pend_reg   <= acc_a && hwrite;
      wr_addr_reg   <= addr_a;
      if (rd_a) begin
        hrdata_reg <= rd_val;
      end
    end
  end

  // Set wins over the read-clear so an event landing on the read is kept
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg    <= hffc_pkg::CFG_RESET;
      mask_reg   <= hffc_pkg::MASK_RESET;
      irq_st_reg <= 8'h00;
      irq_reg    <= 1'b0;
    end else begin
      if (wr_pend_reg && (wr_addr_reg == hffc_pkg::ADDR_CFG)) begin
        cfg_reg <= hwdata[7:0];
      end
      if (wr_pend_reg && (wr_addr_reg == hffc_pkg::ADDR_MASK)) begin
        mask_reg <= hwdata[7:0];
      end
      irq_st_reg <= (irq_st_reg & ~ev_clr) | ev_set;
      irq_reg    <= |(((irq_st_reg & ~ev_clr) | ev_set) & ~mask_reg);
    end
  end

  assign hrdata    = {24'h000000, hrdata_reg};
  assign hreadyout = hreadyout_reg;
  assign hresp     = 1'b0;
  assign tx_valid  = tx_valid_reg;
  assign tx_data   = tx_data_reg;
  assign tx_first  = tx_first_reg;
  assign tx_last   = tx_last_reg;
  assign tx_abort  = tx_abort_reg;
  assign irq       = irq_reg;

endmodule : hffc_top

`default_nettype wire

// ===== rtl/hffc_dummy_placeholder_none.sv
// Intentionally empty compile unit
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ===== sim/hffc_chk_sva.sv
// Port-level assertion checker for the frame FIFO host control block
`timescale 1ns/100ps
`default_nettype none
module hffc_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_first,
  input wire logic        tx_last,
  input wire logic        tx_abort,
  input wire logic        tx_ready,
  input wire logic        tx_collision,
  input wire logic        irq
);
  logic cmd_wr_q;
  logic tx_reset_cmd_now;
  // Command writes act in the data phase, so the address phase is remembered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_wr_q <= 1'b0;
    end else if (hready) begin
      cmd_wr_q <= hsel && htrans[1] && hwrite && (haddr[7:2] == hffc_pkg::ADDR_CMD[7:2]);
    end
  end
  assign tx_reset_cmd_now = cmd_wr_q && hready && hwdata[hffc_pkg::CMD_TX_RESET_CMD];
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_zero_wait: assert property ($past(hresetn) |-> hreadyout)
    else $error("hreadyout low outside reset");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  a_offer_holds: assert property (tx_valid && !tx_ready && !tx_collision |=>
    tx_valid && $stable(tx_data) && $stable(tx_first) && $stable(tx_last))
    else $error("offered byte changed before taken");
  a_first_valid: assert property (tx_first |-> tx_valid)
    else $error("tx_first without tx_valid");
  a_last_valid: assert property (tx_last |-> tx_valid)
    else $error("tx_last without tx_valid");
  a_abort_pulse: assert property (tx_abort |=> !tx_abort)
    else $error("tx_abort longer than one cycle");
  a_abort_cause: assert property (tx_abort |-> $past(tx_ready) || $past(tx_collision))
    else $error("tx_abort without link cause");
  a_abort_flush: assert property (tx_abort |=> !tx_valid [*3])
    else $error("queue offers data after abort");
  a_tx_reset_cmd_flush: assert property (tx_reset_cmd_now |=> ##1 !tx_valid [*2])
    else $error("queue offers data after tx reset");
  c_abort: cover property (tx_abort);
  c_last_taken: cover property (tx_valid && tx_ready && tx_last);
  c_irq_rise: cover property ($rose(irq));
endmodule : hffc_chk
bind hffc_top hffc_chk chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hreadyout, .hresp, .tx_valid, .tx_data, .tx_first, .tx_last, .tx_abort,
  .tx_ready, .tx_collision, .irq);
`default_nettype wire

// ===== sim/hffc_link_model.sv
// Serial link side model: takes bytes, reports closing flag, makes collisions
`timescale 1ns/100ps
`default_nettype none
module hffc_link_model (
  input wire logic  hclk,
  input wire logic  hresetn,
  input wire logic  tx_valid,
  input wire logic  tx_last,
  input wire logic  slow,
  input wire logic  hit,
  output logic      tx_ready,
  output logic      tx_flag_done,
  output logic      tx_collision
);
  logic [1:0] ph;
  logic [4:0] fd_cnt;
  // Slow mode takes one byte in four so the host can race the link
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph           <= 2'h0;
      tx_ready     <= 1'b0;
      tx_flag_done <= 1'b0;
      tx_collision <= 1'b0;
      fd_cnt       <= 5'h0;
    end else begin
      ph           <= ph + 2'h1;
      tx_ready     <= !slow || (ph == 2'h2);
      tx_collision <= hit;
      tx_flag_done <= (fd_cnt == 5'h01);
      if (tx_valid && tx_ready && tx_last) begin
        fd_cnt <= 5'h14;
      end else if (fd_cnt != 5'h0) begin
        fd_cnt <= fd_cnt - 5'h01;
      end
    end
  end
endmodule : hffc_link_model
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the frame FIFO host control block
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, mode0, rx_v, rx_end;
  logic        crc, valid_frame_flag, rx_abort_flag, tei, tx_valid, tx_first, tx_last, tx_abort;
  logic        tx_ready, tx_flag_done, tx_collision, irq, slow, hit;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [7:0]  rx_b, tx_data;
  logic [9:0]  exp_q[$];
  int          seed, bad_count, cmp_count, sent, aborts;
  hffc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mode_transparent0(mode0),
    .rx_byte_valid(rx_v), .rx_byte(rx_b), .rx_frame_end(rx_end), .rx_crc_ok(crc),
    .rx_frame_valid(valid_frame_flag), .rx_abort_seen(rx_abort_flag), .rx_tei_hit(tei), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_first(tx_first), .tx_last(tx_last), .tx_abort(tx_abort),
    .tx_ready(tx_ready), .tx_flag_done(tx_flag_done), .tx_collision(tx_collision), .irq(irq));
  hffc_link_model link_u (.hclk(hclk), .hresetn(hresetn), .tx_valid(tx_valid),
    .tx_last(tx_last), .slow(slow), .hit(hit), .tx_ready(tx_ready),
    .tx_flag_done(tx_flag_done), .tx_collision(tx_collision));
  task automatic end_sim();
    if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x & m, e, "register read");
  endtask : rd_chk
  // Bytes dropped by the design (locked or flushed) are not expected on the link
  task automatic put(input int n, input logic frst, input logic lst, input logic keep);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = $random(seed);
      wr(hffc_pkg::ADDR_DATA, {24'h0, b});
      if (keep) exp_q.push_back({frst && i == 0, lst && i == n - 1, b});
    end
  endtask : put
  task automatic rx_frame(input int n, input logic m0);
    logic [7:0] d[$];
    logic [7:0] b;
    logic [3:0] s;
    int         k;
    s = $random(seed);
    k = 0;
    @(posedge hclk);
    {crc, valid_frame_flag, rx_abort_flag, tei} <= s;
    mode0 <= m0;
    repeat (n) begin
      b = $random(seed);
      d.push_back(b);
      @(posedge hclk);
      rx_v <= 1'b1;
      rx_b <= b;
      @(posedge hclk);
      rx_v <= 1'b0;
    end
    @(posedge hclk);
    rx_end <= 1'b1;
    @(posedge hclk);
    rx_end <= 1'b0;
    if (n > 32) begin
      rd_chk(hffc_pkg::ADDR_IRQ, 32'hFF, 32'h80);
      repeat (32) begin
        rd_chk(hffc_pkg::ADDR_DATA, 32'hFF, {24'h0, d[k]});
        k++;
      end
      wr(hffc_pkg::ADDR_CMD, 32'h80);
    end
    rd_chk(hffc_pkg::ADDR_IRQ, 32'hFF, 32'h40);
    rd_chk(hffc_pkg::ADDR_CNT_LO, 32'hFF, 32'(n + 1));
    rd_chk(hffc_pkg::ADDR_CNT_HI, 32'h1F, 32'h0);
    for (; k < n; k++) rd_chk(hffc_pkg::ADDR_DATA, 32'hFF, {24'h0, d[k]});
    rd_chk(hffc_pkg::ADDR_DATA, 32'hFF, {24'h0, s[2], 1'b0, s[3], s[1], s[0] & !m0, 3'h0});
    wr(hffc_pkg::ADDR_CMD, 32'h80);
    rd_chk(hffc_pkg::ADDR_CNT_LO, 32'hFF, 32'h0);
  endtask : rx_frame
  task automatic drain();
    for (int i = 0; i < 2000 && exp_q.size() > 0; i++) @(posedge hclk);
    chk(32'(exp_q.size()), 32'h0, "bytes not sent");
  endtask : drain
  always @(posedge hclk) begin
    if (hresetn && tx_valid && tx_ready) begin
      sent++;
      if (exp_q.size() == 0) chk(32'h1, 32'h0, "unexpected byte");
      else chk({22'h0, tx_first, tx_last, tx_data}, {22'h0, exp_q.pop_front()}, "link byte");
    end
    if (hresetn && tx_abort) aborts++;
  end
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  initial begin
    repeat (30000) @(posedge hclk);
    bad_count++;
    end_sim();
  end
  initial begin
    {hresetn, hsel, hwrite, mode0, rx_v, rx_end, crc, valid_frame_flag, rx_abort_flag, tei, slow, hit} = '0;
    {haddr, hwdata, htrans, rx_b} = '0;
    seed = 23;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(hffc_pkg::ADDR_CFG, 32'hFF, 32'h0);
    rd_chk(hffc_pkg::ADDR_MASK, 32'hFF, 32'h0);
    rd_chk(hffc_pkg::ADDR_STATUS, 32'hC0, 32'h40);
    wr(8'h20, 32'hFF);
    rd_chk(8'h20, 32'hFFFFFFFF, 32'h0);
    wr(hffc_pkg::ADDR_CMD, 32'h01);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h1, "irq raised");
    rd_chk(hffc_pkg::ADDR_IRQ, 32'hFF, 32'h10);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    wr(hffc_pkg::ADDR_MASK, 32'h10);
    wr(hffc_pkg::ADDR_CMD, 32'h01);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h0, "irq masked");
    rd_chk(hffc_pkg::ADDR_IRQ, 32'hFF, 32'h10);
    wr(hffc_pkg::ADDR_MASK, 32'h0);
    rx_frame(36, 1'b0);
    rx_frame(4, 1'b1);
    slow <= 1'b1;
    put(12, 1'b1, 1'b1, 1'b1);
    wr(hffc_pkg::ADDR_CMD, 32'h0A);
    rd_chk(hffc_pkg::ADDR_IRQ, 32'hFF, 32'h0);
    drain();
    repeat (40) @(posedge hclk);
    rd_chk(hffc_pkg::ADDR_IRQ, 32'hFF, 32'h10);
    wr(hffc_pkg::ADDR_CFG, 32'h20);
    rd_chk(hffc_pkg::ADDR_CFG, 32'hFF, 32'h20);
    put(17, 1'b0, 1'b0, 1'b0);
    rd_chk(hffc_pkg::ADDR_STATUS, 32'h80, 32'h0);
    wr(hffc_pkg::ADDR_CMD, 32'h01);
    rd_chk(hffc_pkg::ADDR_STATUS, 32'hC0, 32'h40);
    put(17, 1'b0, 1'b0, 1'b0);
    rd_chk(hffc_pkg::ADDR_STATUS, 32'h80, 32'h80);
    wr(hffc_pkg::ADDR_CFG, 32'h0);
    wr(hffc_pkg::ADDR_CMD, 32'h01);
    rd_chk(hffc_pkg::ADDR_STATUS, 32'hC0, 32'h40);
    put(32, 1'b0, 1'b0, 1'b0);
    rd_chk(hffc_pkg::ADDR_STATUS, 32'h80, 32'h0);
    wr(hffc_pkg::ADDR_CMD, 32'h01);
    rd_chk(hffc_pkg::ADDR_IRQ, 32'h10, 32'h10);
    slow <= 1'b0;
    put(4, 1'b1, 1'b0, 1'b1);
    wr(hffc_pkg::ADDR_CMD, 32'h08);
    for (int i = 0; i < 500 && aborts == 0; i++) @(posedge hclk);
    put(2, 1'b0, 1'b0, 1'b0);
    rd_chk(hffc_pkg::ADDR_IRQ, 32'h0C, 32'h04);
    chk(32'(aborts), 32'h1, "underrun abort");
    put(1, 1'b1, 1'b1, 1'b1);
    wr(hffc_pkg::ADDR_CMD, 32'h0A);
    drain();
    repeat (40) @(posedge hclk);
    rd_chk(hffc_pkg::ADDR_IRQ, 32'h10, 32'h10);
    slow <= 1'b1;
    sent = 0;
    put(32, 1'b1, 1'b0, 1'b1);
    wr(hffc_pkg::ADDR_CMD, 32'h08);
    rd_chk(hffc_pkg::ADDR_IRQ, 32'h10, 32'h10);
    put(8, 1'b0, 1'b1, 1'b1);
    wr(hffc_pkg::ADDR_CMD, 32'h0A);
    for (int i = 0; i < 1000 && sent < 34; i++) @(posedge hclk);
    hit <= 1'b1;
    @(posedge hclk);
    hit <= 1'b0;
    for (int i = 0; i < 100 && aborts < 2; i++) @(posedge hclk);
    rd_chk(hffc_pkg::ADDR_IRQ, 32'h0C, 32'h08);
    exp_q.delete();
    end_sim();
  end
endmodule : tb
`default_nettype wire
